// ==== core/mrr_result_bank.sv ====
/*
  Metering result register bank: RMS, power and line frequency results, the
  active and custom energy accumulators and their freeze registers.
  Assumes a serial port engine on clk_sys presents one-cycle read strobes with
  an address, and that the metering control words come from their registers.
*/
// Behaviour
// - RMS results are 24-bit signed raw values
// - RMS and power refresh at slow or fast rate
// - Frequency count is ticks of clock over eight
// - Frequency update follows the period field setting
// - Period field picks 32, 4, 8, 16 line cycles
// - Wide frequency register, same as primary when small
// - Active power results are 32-bit two's complement
// - Power A from channel A, B from B
// - Reactive power from selected channel, A by default
// - Accumulating active energy flags overflow on wrap
// - Read-clear bit makes reads zero energy registers
// - Active energy counts active pulse outputs
// - Accumulating custom energy flags overflow on wrap
// - Custom energy counts custom pulses, source selectable
// - Active freeze register: read-clear or periodic copy
// - Custom freeze register: read-clear or periodic copy
// - Source field picks reactive, sum, custom, B
// - Rate bit zero slow, one fast refresh
// - Twice counter magnitude at nonzero threshold fires pulse
`timescale 1ns/1ps
`default_nettype none
`include "mrr_regs.svh"

module mrr_result_bank #(
  parameter int unsigned SLOW_CYC = `MRR_SLOW_PERIOD_NS / `MRR_CLK_PERIOD_NS,
  parameter int unsigned FAST_CYC = `MRR_FAST_PERIOD_NS / `MRR_CLK_PERIOD_NS,
  parameter int unsigned FREEZE_CYC = `MRR_FREEZE_PERIOD_NS / `MRR_CLK_PERIOD_NS,
  parameter int unsigned FREQ_W = 28
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic line_zero_cross,
  input wire mrr_pkg::mrr_meas_s meas,
  input wire logic meas_valid,
  input wire logic [15:0] metering_control_one,
  input wire logic [15:0] metering_control_two,
  input wire logic [31:0] custom_power_value,
  input wire logic [15:0] pulse_threshold_constant,
  input wire logic reactive_chan_b_select,
  input wire logic rd_stb,
  input wire logic [6:0] rd_addr,
  output logic [31:0] rd_data,
  output logic active_pulse_output,
  output logic custom_pulse_output,
  output logic active_energy_overflow_flag,
  output logic custom_energy_overflow_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  wire logic read_clear_mode; // Energy registers clear on read
  wire logic energy_freeze_bit; // Periodic copy into freeze registers
  wire logic update_rate_select; // Fast refresh when high
  wire logic [1:0] custom_energy_source_select;
  wire logic [1:0] frequency_period_select;

  assign read_clear_mode = metering_control_one[`MRR_CTL1_READ_CLEAR_BIT];
  assign energy_freeze_bit = metering_control_two[`MRR_CTL2_FREEZE_BIT];
  assign update_rate_select = metering_control_two[`MRR_CTL2_UPDATE_RATE_BIT];
  assign custom_energy_source_select =
    metering_control_two[`MRR_CTL2_SOURCE_HI:`MRR_CTL2_SOURCE_LO];
  assign frequency_period_select =
    metering_control_two[`MRR_CTL2_FREQ_PERIOD_HI:`MRR_CTL2_FREQ_PERIOD_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Refresh timer for RMS and power results

  logic [21:0] rate_cnt_reg; // Cycles since last refresh
  logic [21:0] rate_cnt_next;
  wire logic [21:0] rate_limit;
  wire logic refresh_tick;

  assign rate_limit = update_rate_select ? 22'(FAST_CYC - 1) : 22'(SLOW_CYC - 1);
  // Compare with >= so a switch to the fast rate never strands the counter
  assign refresh_tick = (rate_cnt_reg >= rate_limit);
  assign rate_cnt_next = refresh_tick ? 22'h00_0000 : rate_cnt_reg + 22'h00_0001;

  // Refresh counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rate_cnt_reg <= 22'h00_0000;
    end else begin
      rate_cnt_reg <= rate_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RMS and power results, all loaded on the same edge

  logic [23:0] irms_a_reg; // Raw signed RMS; read zero-extended, so a set top bit reaches the host unchanged
  logic [23:0] irms_b_reg;
  logic [23:0] vrms_reg;
  logic [31:0] pwr_a_reg;
  logic [31:0] pwr_b_reg;
  logic [31:0] pwr_q_reg;
  wire logic [31:0] var_sel; // Reactive power of chosen channel

  assign var_sel = reactive_chan_b_select ? meas.var_b : meas.var_a;

  // One edge loads every word so a read never mixes two refreshes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irms_a_reg <= 24'(`MRR_RESULT_RESET);
      irms_b_reg <= 24'(`MRR_RESULT_RESET);
      vrms_reg <= 24'(`MRR_RESULT_RESET);
      pwr_a_reg <= `MRR_RESULT_RESET;
      pwr_b_reg <= `MRR_RESULT_RESET;
      pwr_q_reg <= `MRR_RESULT_RESET;
    end else if (refresh_tick) begin
      irms_a_reg <= meas.irms_a;
      irms_b_reg <= meas.irms_b;
      vrms_reg <= meas.vrms;
      pwr_a_reg <= meas.pwr_a;
      pwr_b_reg <= meas.pwr_b;
      pwr_q_reg <= var_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line frequency measurement

  logic zc_s1_reg; // Synchroniser first stage
  logic zc_s2_reg; // Synchroniser second stage
  logic zc_prev_reg; // Edge detector history
  logic [2:0] presc_reg; // Divide-by-eight prescaler
  mrr_pkg::mrr_freq_e fstate_reg;
  mrr_pkg::mrr_freq_e fstate_next;
  logic [FREQ_W-1:0] fcnt_reg; // Prescaled ticks over the window
  logic [FREQ_W-1:0] fcnt_next;
  logic [5:0] fedge_reg; // Line cycles seen in window
  logic [5:0] fedge_next;
  logic [23:0] freq_wide_reg;
  logic [23:0] freq_wide_next;
  wire logic zc_rise;
  wire logic presc_tick;
  wire logic [5:0] win_cycles;
  wire logic [2:0] win_shift;
  wire logic win_done;
  wire logic [FREQ_W-1:0] fcnt_avg;
  wire logic [15:0] freq_narrow;

  assign zc_rise = zc_s2_reg & ~zc_prev_reg;
  assign presc_tick = (presc_reg == 3'(`MRR_FREQ_PRESCALE - 1));
  // Window lengths are powers of two so the average is a plain shift
  assign win_cycles = (frequency_period_select == 2'h0) ? 6'h20 :
                      (frequency_period_select == 2'h1) ? 6'h04 :
                      (frequency_period_select == 2'h2) ? 6'h08 : 6'h10;
  assign win_shift = (frequency_period_select == 2'h0) ? 3'h5 :
                     (frequency_period_select == 2'h1) ? 3'h2 :
                     (frequency_period_select == 2'h2) ? 3'h3 : 3'h4;
  assign win_done = zc_rise && (fedge_reg + 6'h01 >= win_cycles);
  assign fcnt_avg = fcnt_reg >> win_shift;
  // The narrow register saturates below about 19 Hz; the wide one holds far lower frequencies
  assign freq_narrow = (freq_wide_reg > 24'h00_ffff) ? 16'hffff : freq_wide_reg[15:0];

  // Measurement sequencer: wait for a first crossing, then time the window
  always_comb begin
    fstate_next = fstate_reg;
    fcnt_next = fcnt_reg;
    fedge_next = fedge_reg;
    freq_wide_next = freq_wide_reg;
    case (fstate_reg)
      mrr_pkg::MRR_FRQ_WAIT: begin
        if (zc_rise) begin
          fstate_next = mrr_pkg::MRR_FRQ_COUNT;
          // Keep this cycle's tick so a window spans exactly N line periods
          fcnt_next = FREQ_W'(presc_tick);
          fedge_next = 6'h00;
        end
      end
      mrr_pkg::MRR_FRQ_COUNT: begin
        if (presc_tick && !(&fcnt_reg)) begin
          fcnt_next = fcnt_reg + FREQ_W'(1);
        end
        if (win_done) begin
          // Saturate the average into the 24-bit result
          freq_wide_next = (fcnt_avg > FREQ_W'(24'hff_ffff)) ? 24'hff_ffff :
                           fcnt_avg[23:0];
          fcnt_next = FREQ_W'(presc_tick);
          fedge_next = 6'h00;
        end else if (zc_rise) begin
          fedge_next = fedge_reg + 6'h01;
        end
      end
      default: begin
        fstate_next = mrr_pkg::MRR_FRQ_WAIT;
      end
    endcase
  end

  // Frequency flip-flops; the pin passes two stages before any logic
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      zc_s1_reg <= 1'b0;
      zc_s2_reg <= 1'b0;
      zc_prev_reg <= 1'b0;
      presc_reg <= 3'h0;
      fstate_reg <= mrr_pkg::MRR_FRQ_WAIT;
      fcnt_reg <= '0;
      fedge_reg <= 6'h00;
      freq_wide_reg <= 24'h00_0000;
    end else begin
      zc_s1_reg <= line_zero_cross;
      zc_s2_reg <= zc_s1_reg;
      zc_prev_reg <= zc_s2_reg;
      presc_reg <= presc_reg + 3'h1;
      fstate_reg <= fstate_next;
      fcnt_reg <= fcnt_next;
      fedge_reg <= fedge_next;
      freq_wide_reg <= freq_wide_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy pulse generation

  wire logic [31:0] custom_power_sel;
  wire logic [1:0] pulse_evt; // Index 0 active, 1 custom

  assign custom_power_sel = (custom_energy_source_select == 2'h0) ? var_sel :
                            (custom_energy_source_select == 2'h1) ?
                              32'(meas.pwr_a + meas.pwr_b) :
                            (custom_energy_source_select == 2'h2) ? custom_power_value :
                            meas.pwr_b;

  mrr_pulse_gen u_active_pulse (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sample_valid(meas_valid),
    .power(meas.pwr_a),
    .threshold(pulse_threshold_constant),
    .pulse(pulse_evt[0])
  );

  mrr_pulse_gen u_custom_pulse (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sample_valid(meas_valid),
    .power(custom_power_sel),
    .threshold(pulse_threshold_constant),
    .pulse(pulse_evt[1])
  );

  assign active_pulse_output = pulse_evt[0];
  assign custom_pulse_output = pulse_evt[1];

  ////////////////////////////////////////////////////////////////////////////
  // Freeze timer

  logic [22:0] frz_cnt_reg; // Cycles since last freeze
  wire logic freeze_tick;

  assign freeze_tick = (frz_cnt_reg == 23'(FREEZE_CYC - 1));

  // Free-running freeze period counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frz_cnt_reg <= 23'h00_0000;
    end else begin
      frz_cnt_reg <= freeze_tick ? 23'h00_0000 : frz_cnt_reg + 23'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy accumulators and freeze registers

  logic [23:0] acc_reg [2]; // Accumulators, 0 active, 1 custom
  logic [23:0] frz_reg [2]; // Freeze registers
  wire logic [1:0] ovf_evt;

  for (genvar i = 0; i < 2; i++) begin : g_energy
    wire logic [6:0] acc_addr;
    wire logic [6:0] frz_addr;
    wire logic rd_acc;
    wire logic rd_frz;
    wire logic acc_clr;
    wire logic [23:0] acc_next;
    wire logic [23:0] frz_next;

    assign acc_addr = (i == 0) ? `MRR_ADDR_ACT_ACC : `MRR_ADDR_CUS_ACC;
    assign frz_addr = (i == 0) ? `MRR_ADDR_ACT_FRZ : `MRR_ADDR_CUS_FRZ;
    assign rd_acc = rd_stb && (rd_addr == acc_addr);
    assign rd_frz = rd_stb && (rd_addr == frz_addr);
    // Clear first, then count, so a pulse in the clearing cycle survives
    assign acc_clr = (read_clear_mode && rd_acc) || (energy_freeze_bit && freeze_tick);
    assign acc_next = (acc_clr ? `MRR_ENERGY_RESET : acc_reg[i]) + {23'h00_0000, pulse_evt[i]};
    assign ovf_evt[i] = pulse_evt[i] && !read_clear_mode && !acc_clr && (&acc_reg[i]);
    // Frozen copy takes the count before this cycle's pulse, which stays in acc
    assign frz_next = energy_freeze_bit ? (freeze_tick ? acc_reg[i] : frz_reg[i]) :
                      ((rd_frz ? `MRR_ENERGY_RESET : frz_reg[i]) +
                       {23'h00_0000, pulse_evt[i]});

    // Energy flip-flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        acc_reg[i] <= `MRR_ENERGY_RESET;
        frz_reg[i] <= `MRR_ENERGY_RESET;
      end else begin
        acc_reg[i] <= acc_next;
        frz_reg[i] <= frz_next;
      end
    end

    acc_wrap_a:
      assert property (@(posedge clk_sys) disable iff (!arst_n)
        (pulse_evt[i] && !acc_clr && acc_reg[i] == 24'hff_ffff)
          |=> (acc_reg[i] == 24'h00_0000))
      else $error("Energy accumulator did not wrap to zero");

    acc_rdclr_a:
      assert property (@(posedge clk_sys) disable iff (!arst_n)
        (read_clear_mode && rd_acc && !pulse_evt[i]) |=> (acc_reg[i] == 24'h00_0000))
      else $error("Energy accumulator not cleared by read");

    frz_copy_a:
      assert property (@(posedge clk_sys) disable iff (!arst_n)
        (energy_freeze_bit && freeze_tick)
          |=> (frz_reg[i] == $past(acc_reg[i])) && (acc_reg[i] == {23'h0, $past(pulse_evt[i])}))
      else $error("Freeze copy or source clear missing");
  end

  // Overflow events are one-cycle pulses to the flag register
  logic [1:0] ovf_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf_reg <= 2'h0;
    end else begin
      ovf_reg <= ovf_evt;
    end
  end

  assign active_energy_overflow_flag = ovf_reg[0];
  assign custom_energy_overflow_flag = ovf_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection

  wire logic [31:0] rd_mux;

  assign rd_mux =
    (rd_addr == `MRR_ADDR_CUR_A_RMS) ? {8'h00, irms_a_reg} :
    (rd_addr == `MRR_ADDR_CUR_B_RMS) ? {8'h00, irms_b_reg} :
    (rd_addr == `MRR_ADDR_VOLT_RMS) ? {8'h00, vrms_reg} :
    (rd_addr == `MRR_ADDR_LINE_FREQ) ? {16'h0000, freq_narrow} :
    (rd_addr == `MRR_ADDR_PWR_A) ? pwr_a_reg :
    (rd_addr == `MRR_ADDR_PWR_B) ? pwr_b_reg :
    (rd_addr == `MRR_ADDR_PWR_Q) ? pwr_q_reg :
    (rd_addr == `MRR_ADDR_ACT_ACC) ? {8'h00, acc_reg[0]} :
    (rd_addr == `MRR_ADDR_ACT_FRZ) ? {8'h00, frz_reg[0]} :
    (rd_addr == `MRR_ADDR_CUS_ACC) ? {8'h00, acc_reg[1]} :
    (rd_addr == `MRR_ADDR_CUS_FRZ) ? {8'h00, frz_reg[1]} :
    (rd_addr == `MRR_ADDR_LINE_FREQ_WIDE) ? {8'h00, freq_wide_reg} :
    32'h0000_0000;

  // Read data captures the value before any read-clear takes effect
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_stb) begin
      rd_data <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  result_load_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      refresh_tick |=> (pwr_a_reg == $past(meas.pwr_a)) && (irms_b_reg == $past(meas.irms_b)))
    else $error("Results not loaded together at refresh");

  result_hold_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      !refresh_tick |=> $stable(pwr_q_reg) && $stable(vrms_reg))
    else $error("Result changed between refreshes");

  rate_bound_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      (update_rate_select && $stable(update_rate_select)) |-> (rate_cnt_reg < 22'(FAST_CYC)))
    else $error("Fast refresh period exceeded");

  freq_sat_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      (freq_wide_reg <= 24'h00_ffff) |-> (freq_narrow == freq_wide_reg[15:0]))
    else $error("Narrow frequency differs from wide value");

  freq_win_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      (fstate_reg == mrr_pkg::MRR_FRQ_COUNT && zc_rise && frequency_period_select == 2'h1
       && fedge_reg == 6'h03) |=> (fedge_reg == 6'h00))
    else $error("Four-cycle frequency window not closed");

  react_sel_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      (refresh_tick && !reactive_chan_b_select) |=> (pwr_q_reg == $past(meas.var_a)))
    else $error("Reactive result not from channel A");

  ovf_flag_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      ovf_evt[1] |=> custom_energy_overflow_flag ##1 !custom_energy_overflow_flag
        || ovf_evt[1])
    else $error("Custom overflow event not flagged");

  pulse_count_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pulse_evt[0] && !g_energy[0].acc_clr) |=> (acc_reg[0] == $past(acc_reg[0]) + 24'h00_0001))
    else $error("Active pulse not counted");

endmodule
`default_nettype wire

// ==== core/mrr_regs.svh ====
/*
  Register offsets, control field positions and timing figures of the metering
  result bank. Assumes a 7-bit register address space on the serial port and a
  10 MHz system clock.
*/
`ifndef MRR_REGS_SVH
`define MRR_REGS_SVH

// Result register offsets (register index on the serial port)
`define MRR_ADDR_CUR_A_RMS 7'h22
`define MRR_ADDR_CUR_B_RMS 7'h23
`define MRR_ADDR_VOLT_RMS 7'h24
`define MRR_ADDR_LINE_FREQ 7'h25
`define MRR_ADDR_PWR_A 7'h26
`define MRR_ADDR_PWR_B 7'h27
`define MRR_ADDR_PWR_Q 7'h28
`define MRR_ADDR_ACT_ACC 7'h29
`define MRR_ADDR_ACT_FRZ 7'h2a
`define MRR_ADDR_CUS_ACC 7'h2b
`define MRR_ADDR_CUS_FRZ 7'h2c
`define MRR_ADDR_LINE_FREQ_WIDE 7'h35

// Field positions in the two metering control words
`define MRR_CTL1_READ_CLEAR_BIT 15
`define MRR_CTL2_FREQ_PERIOD_HI 13
`define MRR_CTL2_FREQ_PERIOD_LO 12
`define MRR_CTL2_UPDATE_RATE_BIT 7
`define MRR_CTL2_SOURCE_HI 5
`define MRR_CTL2_SOURCE_LO 4
`define MRR_CTL2_FREEZE_BIT 3

// Reset values of the result registers
`define MRR_RESULT_RESET 32'h0000_0000
`define MRR_ENERGY_RESET 24'h00_0000

// Timing figures, in nanoseconds, and the clock period
`define MRR_CLK_PERIOD_NS 100
`define MRR_SLOW_PERIOD_NS 294117647
`define MRR_FAST_PERIOD_NS 71520526
`define MRR_FREEZE_PERIOD_NS 572139700
`define MRR_FREQ_PRESCALE 8

`endif

// ==== core/mrr_pkg.sv ====
/*
  Types shared by the metering result bank files.
  Assumes the measurement values come from a datapath on the same clock.
*/
package mrr_pkg;

  // Raw measurement values offered by the datapath
  typedef struct packed {
    logic [23:0] irms_a;
    logic [23:0] irms_b;
    logic [23:0] vrms;
    logic [31:0] pwr_a;
    logic [31:0] pwr_b;
    logic [31:0] var_a;
    logic [31:0] var_b;
  } mrr_meas_s;

  // Line frequency measurement states
  typedef enum logic [0:0] {
    MRR_FRQ_WAIT,
    MRR_FRQ_COUNT
  } mrr_freq_e;

endpackage

// ==== core/mrr_pulse_gen.sv ====
/*
  Fast pulse counter: integrates a signed power value per sample and fires one
  energy pulse whenever twice the counter magnitude reaches a nonzero threshold.
  Assumes power samples and threshold are on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module mrr_pulse_gen #(
  parameter int unsigned CW = 40
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [31:0] power,
  input wire logic [15:0] threshold,
  output logic pulse
);

  logic signed [CW-1:0] cnt_reg; // Fast counter, signed
  logic signed [CW-1:0] cnt_next;
  logic pulse_reg;
  wire logic cnt_neg; // Counter below zero
  wire logic [CW-1:0] cnt_mag; // Absolute value
  wire logic [CW-1:0] twice_mag;
  wire logic [CW-1:0] thr_ext;
  wire logic [CW-1:0] step; // Half threshold, rounded up
  wire logic [CW-1:0] power_ext; // Sign-extended sample
  wire logic fire;

  assign cnt_neg = cnt_reg[CW-1];
  assign cnt_mag = cnt_neg ? CW'(-cnt_reg) : cnt_reg;
  assign twice_mag = {cnt_mag[CW-2:0], 1'b0};
  assign thr_ext = {{(CW-16){1'b0}}, threshold};
  assign step = CW'((thr_ext + CW'(1)) >> 1);
  assign power_ext = {{(CW-32){power[31]}}, power};
  // A zero threshold would fire every cycle, so it stops the output instead
  assign fire = (threshold != 16'h0000) && (twice_mag >= thr_ext);

  // Integrate the sample and take out the energy of a fired pulse
  always_comb begin
    cnt_next = cnt_reg;
    if (sample_valid) begin
      cnt_next = cnt_next + power_ext;
    end
    if (fire) begin
      cnt_next = cnt_neg ? cnt_next + step : cnt_next - step;
    end
  end

  // Counter and pulse flip-flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse_reg <= fire;
    end
  end

  assign pulse = pulse_reg;

  pulse_fire_a:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
      (threshold != 16'h0000 && twice_mag >= thr_ext) |=> pulse)
    else $error("Pulse missing after threshold reached");

endmodule
`default_nettype wire

// ==== bench/mrr_host_model.sv ====
/*
  Host side model: a microcontroller reading result registers through the
  serial engine's read strobe. Assumes the bank samples strobes on rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mrr_host_model (
  input wire logic clk_sys,
  output logic rd_stb,
  output logic [6:0] rd_addr,
  input wire logic [31:0] rd_data
);
  // Idle bus: no strobe pending
  initial begin
    rd_stb = 1'b0;
    rd_addr = 7'h00;
  end
  // One read: strobe held over one rising edge, data taken a cycle later
  task automatic read(input logic [6:0] addr, output logic [31:0] data);
    @(negedge clk_sys);
    rd_stb = 1'b1;
    rd_addr = addr;
    @(negedge clk_sys);
    rd_stb = 1'b0;
    // Park the address on its inverse so a stale index is never reused
    rd_addr = ~addr;
    @(negedge clk_sys);
    data = rd_data;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
/*
  Self-checking bench of the result bank: reset, refresh, energy, source,
  freeze and frequency. Assumes the short refresh and freeze counts below.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic zc = 1'b0;
  logic zc_on = 1'b0;
  mrr_pkg::mrr_meas_s meas = '0;
  logic meas_valid = 1'b0;
  logic [15:0] ctl1 = 16'h0000;
  logic [15:0] ctl2 = 16'h0000;
  logic [31:0] cpv = 32'h0000_0000;
  logic [15:0] thr = 16'h0010; // Threshold 16: one sample of 8 fires one pulse
  logic qsel = 1'b0;
  logic rd_stb;
  logic [6:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] v;
  logic [31:0] w;
  int errors = 0;
  int checks_done = 0;
  logic pa, pq, oa, oq; // Pulse outputs and overflow events
  int n_pa = 0, n_pq = 0, n_ovf = 0;
  //////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Line crossings, 400 clocks a cycle while enabled, so the count is 50
  always begin
    #20000;
    zc = zc_on ? ~zc : 1'b0;
  end
  mrr_result_bank #(.SLOW_CYC(40), .FAST_CYC(20), .FREEZE_CYC(64)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .line_zero_cross(zc), .meas(meas),
    .meas_valid(meas_valid), .metering_control_one(ctl1),
    .metering_control_two(ctl2), .custom_power_value(cpv),
    .pulse_threshold_constant(thr), .reactive_chan_b_select(qsel),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
    .active_pulse_output(pa), .custom_pulse_output(pq),
    .active_energy_overflow_flag(oa), .custom_energy_overflow_flag(oq));
  mrr_host_model u_host (
    .clk_sys(clk_sys), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data));
  // Count pulses and overflow events on the falling edge, where they are settled
  always @(negedge clk_sys) begin
    if (pa === 1'b1) n_pa++;
    if (pq === 1'b1) n_pq++;
    if (oa !== 1'b0 || oq !== 1'b0) n_ovf++;
  end
  //////////////////////////////////////////////////////////////////////
  // Compare and count; unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    u_host.read(a, v);
    check(v, exp);
  endtask
  // One power sample per five cycles, then let the last pulse land
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      meas_valid = 1'b1;
      @(negedge clk_sys);
      meas_valid = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask
  // Poll the accumulator until a freeze copy has emptied it, bounded
  task automatic wait_copy;
    int n;
    n = 0;
    do begin
      u_host.read(7'h29, v);
      n++;
    end while (v !== 32'h0 && n < 60);
    check(v, 32'h0);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Reset values, and an unmapped index that reads zero
  task automatic t_reset;
    for (int a = 'h22; a <= 'h2c; a++) begin
      rd_chk(7'(a), 32'h0);
    end
    rd_chk(7'h35, 32'h0);
    rd_chk(7'h30, 32'h0);
    $display("test reset done");
  endtask
  // Results load raw; then the fast rate and the channel B reactive choice
  task automatic t_refresh;
    meas = {24'h80_0001, 24'h12_3456, 24'h65_4321, 32'h8000_0007,
            32'h1234_5678, 32'hfedc_ba98, 32'h0000_0042};
    repeat (90) @(negedge clk_sys);
    rd_chk(7'h22, 32'h0080_0001);
    rd_chk(7'h23, 32'h0012_3456);
    rd_chk(7'h24, 32'h0065_4321);
    rd_chk(7'h26, 32'h8000_0007);
    rd_chk(7'h27, 32'h1234_5678);
    rd_chk(7'h28, 32'hfedc_ba98);
    ctl2 = 16'h0080;
    qsel = 1'b1;
    // Change lands just after a slow-rate instant, so only the fast rate loads it
    repeat (53) @(negedge clk_sys);
    meas.vrms = 24'h00_0abc;
    // Over one fast period, short of the next slow instant
    repeat (22) @(negedge clk_sys);
    rd_chk(7'h28, 32'h0000_0042);
    rd_chk(7'h24, 32'h0000_0abc);
    $display("test refresh done");
  endtask
  // Pulse counting, accumulate mode, then read-clear mode
  task automatic t_energy;
    meas = '0;
    meas.pwr_a = 32'h0000_0008;
    pulses(5);
    check(n_pa, 32'h5);
    check(n_ovf, 32'h0);
    rd_chk(7'h29, 32'h5);
    rd_chk(7'h29, 32'h5);
    rd_chk(7'h2a, 32'h5);
    rd_chk(7'h2a, 32'h0);
    ctl1 = 16'h8000;
    rd_chk(7'h29, 32'h5);
    rd_chk(7'h29, 32'h0);
    $display("test energy done");
  endtask
  // Every custom source code, only the selected input carrying power
  task automatic t_source;
    qsel = 1'b0;
    for (int k = 0; k < 4; k++) begin
      meas = '0;
      cpv = (k == 2) ? 32'h8 : 32'h0;
      meas.var_a = (k == 0) ? 32'h8 : 32'h0;
      meas.pwr_a = (k == 1) ? 32'h8 : 32'h0;
      meas.pwr_b = (k == 3) ? 32'h8 : 32'h0;
      ctl2 = {10'h000, 2'(k), 4'h0};
      u_host.read(7'h2b, v);
      pulses(3);
      rd_chk(7'h2b, 32'h3);
    end
    check(n_pq, 32'hc);
    $display("test source done");
  endtask
  // Periodic copy into both freeze registers, sources emptied
  task automatic t_freeze;
    ctl1 = 16'h0000;
    ctl2 = 16'h0008;
    cpv = 32'h0;
    meas = '0;
    meas.pwr_a = 32'h0000_0008;
    meas.var_a = 32'h0000_0008;
    pulses(1);
    wait_copy;
    pulses(3);
    wait_copy;
    rd_chk(7'h2a, 32'h3);
    rd_chk(7'h2c, 32'h3);
    rd_chk(7'h2b, 32'h0);
    $display("test freeze done");
  endtask
  // Every period code; waits cover the old window plus the new one
  task automatic t_freq;
    zc_on = 1'b1;
    for (int k = 1; k <= 4; k++) begin
      ctl2 = {2'b00, 2'(k), 12'h000};
      repeat ((2 * (2 << k) + 2) * 400) @(negedge clk_sys);
      u_host.read(7'h25, w);
      u_host.read(7'h35, v);
      check({31'h0, (w >= 32'h31 && w <= 32'h33)}, 32'h1);
      check(v, w);
    end
    $display("test frequency done");
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence, reset held two cycles
  initial begin
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    t_reset;
    t_refresh;
    t_energy;
    t_source;
    t_freeze;
    t_freq;
    stop_test;
  end
  // Watchdog: tests need about 52000 cycles
  initial begin
    #8000000;
    errors++;
    stop_test;
  end
endmodule
`default_nettype wire
